//--- pkg/fmsc_pkg.sv
package fmsc_pkg;

  localparam logic [7:0] FMSC_OFF_MODE     = 8'h3f;
  localparam logic [7:0] FMSC_OFF_POST_LO  = 8'h80;
  localparam logic [7:0] FMSC_OFF_POST_HI  = 8'h81;
  localparam logic [7:0] FMSC_OFF_DEBUG    = 8'h82;
  localparam logic [7:0] FMSC_OFF_BLOCKS   = 8'h83;
  localparam logic [7:0] FMSC_OFF_GAP_LO   = 8'h84;
  localparam logic [7:0] FMSC_OFF_GAP_HI   = 8'h85;
  localparam logic [7:0] FMSC_OFF_STATUS   = 8'h90;
  localparam logic [7:0] FMSC_OFF_IRQ_STAT = 8'h91;
  localparam logic [7:0] FMSC_OFF_IRQ_MASK = 8'h92;

  localparam logic [7:0]  FMSC_RST_MODE   = 8'h00;
  localparam logic [15:0] FMSC_RST_POST   = 16'h0000;
  localparam logic [7:0]  FMSC_RST_DEBUG  = 8'h00;
  localparam logic [7:0]  FMSC_RST_BLOCKS = 8'h01;
  localparam logic [15:0] FMSC_RST_GAP    = 16'h0002;
  localparam logic [15:0] FMSC_GAP_MIN    = 16'h0002;
  localparam logic [15:0] FMSC_GAP_MAX    = 16'h0e1d;

  localparam int FMSC_MODE_LSB    = 0;
  localparam int FMSC_MODE_MSB    = 2;
  localparam int FMSC_PREV_LAST   = 3;
  localparam int FMSC_PREV_SEL    = 4;
  localparam int FMSC_ST_BUSY     = 7;
  localparam int FMSC_ST_TRIG     = 6;
  localparam int FMSC_ST_SOF      = 5;
  localparam int FMSC_ST_WRAP     = 4;
  localparam int FMSC_IRQ_W       = 4;

  localparam logic [2:0] FMSC_MODE_DIRECT = 3'h0;
  localparam logic [2:0] FMSC_MODE_FIFO   = 3'h1;
  localparam logic [2:0] FMSC_MODE_CIRC   = 3'h2;

  localparam logic [7:0] FMSC_TAIL_BYTES  = 8'hb8;

  typedef enum logic [2:0] {
    FMSC_CIRC_IDLE = 3'b001,
    FMSC_CIRC_PRE  = 3'b010,
    FMSC_CIRC_POST = 3'b100
  } fmsc_circ_t;

endpackage : fmsc_pkg

//--- design/fmsc_pin_sync.sv
`timescale 1ns/1ps
module fmsc_pin_sync
  import fmsc_pkg::*;
(
  input  wire logic mclk_i,  // Clock
  input  wire logic rst_i,   // Sync reset
  input  wire logic pin_i,   // Asynchronous pin
  output logic      level_o, // Filtered level
  output logic      rise_o   // One-cycle pulse on rising change
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change counts only once the second and third stages agree
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
    end
    else
    begin
      s1_r   <= pin_i;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      rise_o <= 1'b0;
      if (s2_r == s3_r)
      begin
        level_o <= s3_r;
        rise_o  <= s3_r & ~level_o;
      end
    end
  end

endmodule : fmsc_pin_sync

//--- design/fmsc_status_config.sv
`timescale 1ns/1ps
module fmsc_status_config
  import fmsc_pkg::*;
(
  input  wire logic        mclk_i,         // 50 MHz clock
  input  wire logic        rst_i,          // Sync reset, active high
  input  wire logic [7:0]  addr_i,         // Register byte offset
  input  wire logic [7:0]  wdata_i,        // Write data
  input  wire logic        wr_i,           // Write strobe
  input  wire logic        rd_i,           // Read strobe
  output logic      [7:0]  rdata_o,        // Read data, cycle after rd_i
  input  wire logic        mem_reset_i,    // Memory reset command pulse
  input  wire logic        trigger_pin_i,  // External trigger pin
  input  wire logic        frame_done_i,   // Pulse: a frame was stored
  input  wire logic        mem_full_i,     // Pulse: write pointer hit memory end
  input  wire logic        block_sof_i,    // Level: current block holds a frame start
  input  wire logic        tail_i,         // Level: block tail after next address
  input  wire logic        preview_px0_i,  // Level: top-left preview pixel slot
  input  wire logic [7:0]  data_i,         // Outgoing readout byte
  output logic      [7:0]  data_o,         // Readout byte, status patched in
  output logic             write_en_o,     // Memory accepts frames
  output logic             preview_last_o, // Send latest frame continuously
  output logic             preview_sel_o,  // Send frame at readout address
  output logic      [7:0]  blocks_o,       // Blocks per readout command
  output logic      [15:0] gap_lines_o,    // Line times between sent frames
  output logic      [7:0]  debug_sel_o,    // Scope probe select
  output logic      [7:0]  status_o,       // Live status byte
  output logic             irq_o           // Level interrupt
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0]  mode_r;
  logic [15:0] post_r;
  logic [7:0]  debug_r;
  logic [7:0]  blocks_r;
  logic [15:0] gap_r;

  wire wr_mode    = wr_i && (addr_i == FMSC_OFF_MODE);
  wire wr_post_lo = wr_i && (addr_i == FMSC_OFF_POST_LO);
  wire wr_post_hi = wr_i && (addr_i == FMSC_OFF_POST_HI);
  wire wr_debug   = wr_i && (addr_i == FMSC_OFF_DEBUG);
  wire wr_blocks  = wr_i && (addr_i == FMSC_OFF_BLOCKS);
  wire wr_gap_lo  = wr_i && (addr_i == FMSC_OFF_GAP_LO);
  wire wr_gap_hi  = wr_i && (addr_i == FMSC_OFF_GAP_HI);
  wire wr_istat   = wr_i && (addr_i == FMSC_OFF_IRQ_STAT);
  wire wr_imask   = wr_i && (addr_i == FMSC_OFF_IRQ_MASK);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      mode_r   <= FMSC_RST_MODE;
      post_r   <= FMSC_RST_POST;
      debug_r  <= FMSC_RST_DEBUG;
      blocks_r <= FMSC_RST_BLOCKS;
      gap_r    <= FMSC_RST_GAP;
    end
    else
    begin
      if (wr_mode)
        mode_r <= wdata_i;
      if (wr_post_lo)
        post_r[7:0] <= wdata_i;
      if (wr_post_hi)
        post_r[15:8] <= wdata_i;
      if (wr_debug)
        debug_r <= wdata_i;
      if (wr_blocks)
        blocks_r <= wdata_i;
      if (wr_gap_lo)
        gap_r[7:0] <= wdata_i;
      if (wr_gap_hi)
        gap_r[15:8] <= wdata_i;
    end
  end

  wire [2:0] mode_sel    = mode_r[FMSC_MODE_MSB:FMSC_MODE_LSB];
  wire       is_circ     = (mode_sel == FMSC_MODE_CIRC);
  wire       prev_last   = mode_r[FMSC_PREV_LAST];
  wire       prev_sel    = mode_r[FMSC_PREV_SEL] & ~mode_r[FMSC_PREV_LAST];
  // Values 0 and 1 both mean a single block
  wire [7:0] blocks_eff  = (blocks_r <= FMSC_RST_BLOCKS) ? FMSC_RST_BLOCKS : blocks_r;
  // Out-of-range gaps are clamped so the sender never stalls or races
  wire [15:0] gap_eff    = (gap_r < FMSC_GAP_MIN) ? FMSC_GAP_MIN :
                           (gap_r > FMSC_GAP_MAX) ? FMSC_GAP_MAX : gap_r;

  // ----------------------------------------
  // Trigger synchroniser
  // ----------------------------------------
  logic trig_level;
  logic trig_rise;

  fmsc_pin_sync u_trig_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (trigger_pin_i),
    .level_o (trig_level),
    .rise_o  (trig_rise)
  );

  // ----------------------------------------
  // Circular recording sequence
  // ----------------------------------------
  fmsc_circ_t  circ_r;
  fmsc_circ_t  circ_nxt;
  logic [15:0] post_cnt_r;
  logic        trig_seen_r;
  logic        wrap_r;

  always_comb
  begin
    circ_nxt = circ_r;
    unique case (circ_r)
      FMSC_CIRC_IDLE:
        if (mem_reset_i)
          circ_nxt = FMSC_CIRC_PRE;
      FMSC_CIRC_PRE:
        if (trig_rise)
          circ_nxt = (post_r == FMSC_RST_POST) ? FMSC_CIRC_IDLE : FMSC_CIRC_POST;
      FMSC_CIRC_POST:
        if (frame_done_i && (post_cnt_r == FMSC_RST_POST + 16'h0001))
          circ_nxt = FMSC_CIRC_IDLE;
    endcase
    if (mem_reset_i)
      circ_nxt = FMSC_CIRC_PRE;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      circ_r     <= FMSC_CIRC_IDLE;
      post_cnt_r <= FMSC_RST_POST;
    end
    else
    begin
      circ_r <= circ_nxt;
      if (circ_r == FMSC_CIRC_PRE && trig_rise)
        post_cnt_r <= post_r;
      else if (circ_r == FMSC_CIRC_POST && frame_done_i)
        post_cnt_r <= post_cnt_r - 16'h0001;
    end
  end

  // Flags move only on recording events or memory reset, never on a read
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      trig_seen_r <= 1'b0;
      wrap_r      <= 1'b0;
    end
    else if (mem_reset_i)
    begin
      trig_seen_r <= 1'b0;
      wrap_r      <= 1'b0;
    end
    else
    begin
      if (trig_rise)
        trig_seen_r <= 1'b1;
      if (mem_full_i)
        wrap_r <= 1'b1;
    end
  end

  // Direct and FIFO modes always accept; circular only while armed or counting
  wire busy = !is_circ || (circ_r != FMSC_CIRC_IDLE);

  wire [7:0] status = {busy, trig_seen_r, block_sof_i, wrap_r, mode_r[3:0]};

  // ----------------------------------------
  // Interrupts: busy fall, trigger, wrap, frame start
  // ----------------------------------------
  logic [FMSC_IRQ_W-1:0] istat_r;
  logic [FMSC_IRQ_W-1:0] imask_r;
  logic                  busy_d_r;
  wire  [FMSC_IRQ_W-1:0] ievt = {block_sof_i & ~status_o[FMSC_ST_SOF],
                                 mem_full_i, trig_rise, busy_d_r & ~busy};

  genvar gi;
  generate
    for (gi = 0; gi < FMSC_IRQ_W; gi++)
    begin : g_irq
      // An event in the clearing cycle keeps the bit set
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
          istat_r[gi] <= 1'b0;
        else if (ievt[gi])
          istat_r[gi] <= 1'b1;
        else if (wr_istat && wdata_i[gi])
          istat_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      imask_r  <= '0;
      busy_d_r <= 1'b0;
    end
    else
    begin
      busy_d_r <= busy;
      if (wr_imask)
        imask_r <= wdata_i[FMSC_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Read mux and registered outputs
  // ----------------------------------------
  logic [7:0] rsel;

  always_comb
  begin
    unique case (addr_i)
      FMSC_OFF_MODE:     rsel = mode_r;
      FMSC_OFF_POST_LO:  rsel = post_r[7:0];
      FMSC_OFF_POST_HI:  rsel = post_r[15:8];
      FMSC_OFF_DEBUG:    rsel = debug_r;
      FMSC_OFF_BLOCKS:   rsel = blocks_r;
      FMSC_OFF_GAP_LO:   rsel = gap_r[7:0];
      FMSC_OFF_GAP_HI:   rsel = gap_r[15:8];
      FMSC_OFF_STATUS:   rsel = status;
      FMSC_OFF_IRQ_STAT: rsel = {4'h0, istat_r};
      FMSC_OFF_IRQ_MASK: rsel = {4'h0, imask_r};
      default:           rsel = 8'h00;
    endcase
  end

  // Status is patched into the tail filler outside preview modes and into the first preview pixel in preview modes
  wire patch = (tail_i & ~prev_last & ~prev_sel) | (preview_px0_i & (prev_last | prev_sel));

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rdata_o        <= 8'h00;
      data_o         <= 8'h00;
      write_en_o     <= 1'b0;
      preview_last_o <= 1'b0;
      preview_sel_o  <= 1'b0;
      blocks_o       <= FMSC_RST_BLOCKS;
      gap_lines_o    <= FMSC_RST_GAP;
      debug_sel_o    <= FMSC_RST_DEBUG;
      status_o       <= 8'h00;
      irq_o          <= 1'b0;
    end
    else
    begin
      rdata_o        <= rd_i ? rsel : 8'h00;
      data_o         <= patch ? status : data_i;
      write_en_o     <= busy;
      preview_last_o <= prev_last;
      preview_sel_o  <= prev_sel;
      blocks_o       <= blocks_eff;
      gap_lines_o    <= gap_eff;
      debug_sel_o    <= debug_r;
      status_o       <= status;
      // A set mask bit hides its status bit from the interrupt line
      irq_o          <= |(istat_r & ~imask_r);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_busy_direct;
    @(posedge mclk_i) disable iff (rst_i)
      (!is_circ) |=> write_en_o;
  endproperty
  a_busy_direct: assert property (p_busy_direct) else $error("busy low outside circular");

  property p_trig_sets;
    @(posedge mclk_i) disable iff (rst_i)
      (trig_rise && !mem_reset_i) |=> ##1 status_o[FMSC_ST_TRIG];
  endproperty
  a_trig_sets: assert property (p_trig_sets) else $error("trigger flag not set");

  property p_reset_clears;
    @(posedge mclk_i) disable iff (rst_i)
      mem_reset_i |=> ##1 (!status_o[FMSC_ST_TRIG] && !status_o[FMSC_ST_WRAP]);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("flags survive reset");

  property p_wrap;
    @(posedge mclk_i) disable iff (rst_i)
      (mem_full_i && !mem_reset_i) |=> ##1 status_o[FMSC_ST_WRAP];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");

  property p_mode_bits;
    @(posedge mclk_i) disable iff (rst_i)
      wr_mode |=> ##1 (status_o[3:0] == $past(wdata_i[3:0], 2));
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits not mirrored");

  property p_prev_sel;
    @(posedge mclk_i) disable iff (rst_i)
      preview_sel_o |-> !preview_last_o;
  endproperty
  a_prev_sel: assert property (p_prev_sel) else $error("both preview outputs");

  property p_blocks;
    @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> (blocks_o != 8'h00);
  endproperty
  a_blocks: assert property (p_blocks) else $error("zero block count");

  property p_gap;
    @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> (gap_lines_o >= FMSC_GAP_MIN && gap_lines_o <= FMSC_GAP_MAX);
  endproperty
  a_gap: assert property (p_gap) else $error("gap out of range");

  property p_tail;
    @(posedge mclk_i) disable iff (rst_i)
      (tail_i && !prev_last && !prev_sel) |=> (data_o == $past(status));
  endproperty
  a_tail: assert property (p_tail) else $error("tail not status");

  property p_circ_idle;
    @(posedge mclk_i) disable iff (rst_i)
      (is_circ && circ_r == FMSC_CIRC_IDLE && !mem_reset_i) |=> !write_en_o;
  endproperty
  a_circ_idle: assert property (p_circ_idle) else $error("busy while idle");

  property p_sof;
    @(posedge mclk_i) disable iff (rst_i)
      block_sof_i |=> status_o[FMSC_ST_SOF];
  endproperty
  a_sof: assert property (p_sof) else $error("frame start bit missing");

  property p_prev_last;
    @(posedge mclk_i) disable iff (rst_i)
      mode_r[FMSC_PREV_LAST] |=> preview_last_o;
  endproperty
  a_prev_last: assert property (p_prev_last) else $error("latest preview missing");

  property p_blocks_pass;
    @(posedge mclk_i) disable iff (rst_i)
      (blocks_r > FMSC_RST_BLOCKS) |=> (blocks_o == $past(blocks_r));
  endproperty
  a_blocks_pass: assert property (p_blocks_pass) else $error("block count altered");

endmodule : fmsc_status_config

//--- bench/fmsc_rec_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Recording side: stores one frame every eight cycles
// ------------------------------------------------------------
module fmsc_rec_model (
  input  wire logic        mclk_i,       // Clock
  input  wire logic        rst_i,        // Sync reset
  input  wire logic        write_en_i,   // Memory accepts frames
  input  wire logic        run_i,        // Sensor delivers frames
  output logic             frame_done_o, // Pulse per stored frame
  output logic      [7:0]  byte_o,       // Readout byte, new each cycle
  output logic      [15:0] frames_o      // Frames stored so far
);
  logic [2:0] ph_r;
  wire        store = run_i && write_en_i && (ph_r == 3'h7);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ph_r         <= 3'h0;
      frame_done_o <= 1'b0;
      byte_o       <= 8'h00;
      frames_o     <= 16'h0000;
    end
    else
    begin
      // Stepping by an odd value makes a stale byte stand out
      byte_o       <= byte_o + 8'h35;
      ph_r         <= ph_r + 3'h1;
      frame_done_o <= store;
      frames_o     <= frames_o + {15'h0000, store};
    end
  end
endmodule : fmsc_rec_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb
  import fmsc_pkg::*;
;
  logic        mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, run = 0;
  logic        mem_reset_i = 0, trigger_pin_i = 0, mem_full_i = 0;
  logic        block_sof_i = 0, tail_i = 0, preview_px0_i = 0;
  logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o, data_i, data_o, d;
  logic [7:0]  blocks_o, debug_sel_o, status_o;
  logic        write_en_o, preview_last_o, preview_sel_o, irq_o, frame_done_i;
  logic [15:0] gap_lines_o, frames, n0;
  int          errors = 0, n_tests = 0;

  always #10 mclk_i = ~mclk_i;

  fmsc_status_config i_dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .mem_reset_i, .trigger_pin_i, .frame_done_i, .mem_full_i, .block_sof_i,
    .tail_i, .preview_px0_i, .data_i, .data_o, .write_en_o, .preview_last_o,
    .preview_sel_o, .blocks_o, .gap_lines_o, .debug_sel_o, .status_o, .irq_o);

  fmsc_rec_model i_rec (.mclk_i, .rst_i, .write_en_i(write_en_o), .run_i(run),
    .frame_done_o(frame_done_i), .byte_o(data_i), .frames_o(frames));

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("rdata at %h", a), {8'h00, e}, {8'h00, rdata_o});
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : settle

  task automatic st(input logic [7:0] e);
    repeat (2) @(posedge mclk_i);
    settle();
    chk("status_o", {8'h00, e}, {8'h00, status_o});
  endtask : st

  task automatic pulse(input bit full);
    @(posedge mclk_i);
    if (full)
      mem_full_i <= 1'b1;
    else
      mem_reset_i <= 1'b1;
    @(posedge mclk_i);
    mem_full_i  <= 1'b0;
    mem_reset_i <= 1'b0;
  endtask : pulse

  task automatic trig;
    @(posedge mclk_i);
    trigger_pin_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    trigger_pin_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask : trig

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  logic [15:0] gw [5] = '{16'h0e1d, 16'h0e1e, 16'h0000, 16'h0005, 16'hff00};
  logic [15:0] ge [5] = '{16'h0e1d, 16'h0e1d, 16'h0002, 16'h0005, 16'h0e1d};
  logic [7:0]  bw [3] = '{8'h00, 8'h02, 8'hff};
  logic [7:0]  be [3] = '{8'h01, 8'h02, 8'hff};
  logic [7:0]  mw [4] = '{8'h18, 8'h10, 8'h01, 8'h00};
  logic [15:0] me [4] = '{16'h0588, 16'h0380, 16'h0181, 16'h0180};

  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(FMSC_OFF_MODE, 8'h00);
    rd(FMSC_OFF_POST_LO, 8'h00);
    rd(FMSC_OFF_DEBUG, 8'h00);
    rd(FMSC_OFF_BLOCKS, 8'h01);
    rd(FMSC_OFF_GAP_LO, 8'h02);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00);
    st(8'h80);
    $display("test reset done");
    wr(FMSC_OFF_DEBUG, 8'ha5);
    rd(FMSC_OFF_DEBUG, 8'ha5);
    chk("debug_sel_o", 16'h00a5, {8'h00, debug_sel_o});
    wr(FMSC_OFF_POST_LO, 8'h34);
    wr(FMSC_OFF_POST_HI, 8'h12);
    rd(FMSC_OFF_POST_HI, 8'h12);
    foreach (bw[i])
    begin
      wr(FMSC_OFF_BLOCKS, bw[i]);
      settle();
      chk("blocks_o", {8'h00, be[i]}, {8'h00, blocks_o});
    end
    foreach (gw[i])
    begin
      wr(FMSC_OFF_GAP_LO, gw[i][7:0]);
      wr(FMSC_OFF_GAP_HI, gw[i][15:8]);
      settle();
      chk("gap_lines_o", ge[i], gap_lines_o);
    end
    foreach (mw[i])
    begin
      wr(FMSC_OFF_MODE, mw[i]);
      rd(FMSC_OFF_MODE, mw[i]);
      settle();
      chk("mode outputs", me[i],
          {5'h00, preview_last_o, preview_sel_o, write_en_o, status_o});
    end
    wr(FMSC_OFF_STATUS, 8'h00);
    rd(FMSC_OFF_STATUS, 8'h80);
    $display("test config done");
    // Circular run: three frames after the trigger, then writing stops
    wr(FMSC_OFF_POST_LO, 8'h03);
    wr(FMSC_OFF_POST_HI, 8'h00);
    wr(FMSC_OFF_MODE, 8'h02);
    pulse(1'b0);
    wr(FMSC_OFF_IRQ_STAT, 8'h0f);
    st(8'h82);
    trig();
    st(8'hc2);
    n0 = frames;
    @(posedge mclk_i) run <= 1'b1;
    for (int k = 0; k < 300 && write_en_o !== 1'b0; k++) @(posedge mclk_i) #1;
    chk("write_en_o stop", 16'h0000, {15'h0000, write_en_o});
    st(8'h42);
    chk("frames after trigger", 16'h0003, frames - n0);
    rd(FMSC_OFF_IRQ_STAT, 8'h03);
    chk("irq_o", 16'h0001, {15'h0000, irq_o});
    wr(FMSC_OFF_IRQ_MASK, 8'h03);
    settle();
    chk("irq_o masked", 16'h0000, {15'h0000, irq_o});
    wr(FMSC_OFF_IRQ_MASK, 8'h00);
    wr(FMSC_OFF_IRQ_STAT, 8'h01);
    rd(FMSC_OFF_IRQ_STAT, 8'h02);
    wr(FMSC_OFF_IRQ_STAT, 8'h02);
    settle();
    chk("irq_o cleared", 16'h0000, {15'h0000, irq_o});
    rd(FMSC_OFF_STATUS, 8'h42);
    rd(FMSC_OFF_STATUS, 8'h42);
    pulse(1'b1);
    st(8'h52);
    @(posedge mclk_i) run <= 1'b0;
    pulse(1'b0);
    st(8'h82);
    wr(FMSC_OFF_POST_LO, 8'h00);
    wr(FMSC_OFF_IRQ_STAT, 8'h0f);
    trig();
    st(8'h42);
    $display("test circular done");
    @(posedge mclk_i) block_sof_i <= 1'b1;
    st(8'h62);
    rd(FMSC_OFF_IRQ_STAT, 8'h0b);
    @(posedge mclk_i) tail_i <= 1'b1;
    settle();
    chk("data_o tail", 16'h0062, {8'h00, data_o});
    @(posedge mclk_i) tail_i <= 1'b0;
    wr(FMSC_OFF_MODE, 8'h0a);
    preview_px0_i <= 1'b1;
    settle();
    chk("data_o pixel", 16'h006a, {8'h00, data_o});
    @(posedge mclk_i) preview_px0_i <= 1'b0;
    @(posedge mclk_i);
    repeat (4)
    begin
      @(posedge mclk_i);
      #1 d = data_i;
      @(posedge mclk_i);
      #1 chk("data_o pass", {8'h00, d}, {8'h00, data_o});
    end
    $display("test patch done");
    report_and_stop();
  end

  // Whole run takes a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    report_and_stop();
  end
endmodule : tb
